// *** nfs_host_ctrl.sv ***
// Host-side command sequencer for an asynchronous parallel NOR flash.
// Assumes the flash pins are wired straight to the bus cycle engine outputs and
// that the data pin input is already synchronous to the core clock.
//
// How it works
// - Reset is one F0h write anywhere; it also leaves autoselect.
// - Identification: AAh@555h, 55h@2AAh, 90h@555h enters autoselect.
// - Program: AAh@555h, 55h@2AAh, A0h@555h, then data at target address.
// - Chip erase: six cycles ending 10h@555h erases the whole array.
// - Sector erase ends with 30h at sector address; one at a time, wait.
`timescale 1ns/100ps
`default_nettype none
module nfs_host_ctrl #(
  parameter int ADDR_W = 20
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_cmd_valid,
  input wire nfs_pkg::nfs_op_t i_cmd_op,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_ready,
  output logic o_done,
  output logic o_fail,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_dq_in,
  output logic [7:0] o_dq_out,
  output logic o_dq_oe_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n
);
  import nfs_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL1, S_POLLW1, S_POLL2, S_POLLW2,
    S_RECOVER, S_RECOVERW, S_HALT, S_FINISH
  } nfs_st_t;

  typedef struct packed {
    nfs_st_t st;
    nfs_op_t op;
    logic [2:0] step;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [7:0] prev;
    logic [7:0] rdata;
    logic fail;
    logic fail_seen;
    logic [HALT_CNT_W-1:0] cnt;
    logic start;
    logic wr;
    logic [ADDR_W-1:0] cyc_addr;
    logic [7:0] cyc_data;
    logic ready;
    logic done;
  } nfs_ctl_t;

  nfs_ctl_t s_q, s_d;
  logic eng_done;
  logic [7:0] eng_rdata;

  // ==========================================================================
  // Command sequence table: {write, address, data} for each step of each op.
  function automatic logic [ADDR_W+8:0] seq_word(input nfs_op_t op, input logic [2:0] k,
                                                input logic [ADDR_W-1:0] a,
                                                input logic [7:0] d);
    logic [ADDR_W-1:0] u1;
    logic [ADDR_W-1:0] u2;
    logic [7:0] c3;
    u1 = ADDR_W'(UNLOCK1_ADDR);
    u2 = ADDR_W'(UNLOCK2_ADDR);
    c3 = CMD_ERASE_SETUP;
    if (op == NFS_OP_IDENT) c3 = CMD_AUTOSEL;
    if (op == NFS_OP_PROGRAM) c3 = CMD_PROGRAM;
    case (op)
      NFS_OP_READ: seq_word = {1'b0, a, 8'h00};
      NFS_OP_RESET: seq_word = {1'b1, a, CMD_RESET};
      NFS_OP_SUSPEND: seq_word = {1'b1, a, CMD_SUSPEND};
      NFS_OP_RESUME: seq_word = {1'b1, a, CMD_RESUME};
      default: begin
        case (k)
          3'd0: seq_word = {1'b1, u1, UNLOCK1_DATA};
          3'd1: seq_word = {1'b1, u2, UNLOCK2_DATA};
          3'd2: seq_word = {1'b1, u1, c3};
          3'd3: begin
            if (op == NFS_OP_IDENT) seq_word = {1'b0, a, 8'h00};
            else if (op == NFS_OP_PROGRAM) seq_word = {1'b1, a, d};
            else seq_word = {1'b1, u1, UNLOCK1_DATA};
          end
          3'd4: seq_word = (op == NFS_OP_IDENT) ? {1'b1, a, CMD_RESET} :
                                                   {1'b1, u2, UNLOCK2_DATA};
          default: seq_word = (op == NFS_OP_SECTOR_ERASE) ? {1'b1, a, CMD_SECTOR_ERASE} :
                                                             {1'b1, u1, CMD_CHIP_ERASE};
        endcase
      end
    endcase
  endfunction

  function automatic logic [2:0] last_step(input nfs_op_t op);
    case (op)
      NFS_OP_IDENT: last_step = 3'd4;
      NFS_OP_PROGRAM: last_step = 3'd3;
      NFS_OP_CHIP_ERASE: last_step = 3'd5;
      NFS_OP_SECTOR_ERASE: last_step = 3'd5;
      default: last_step = 3'd0;
    endcase
  endfunction

  // ==========================================================================
  // Operation sequencer
  always_comb begin
    logic [ADDR_W+8:0] w;
    w = seq_word(s_q.op, s_q.step, s_q.addr, s_q.data);
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.done = 1'b0;
    case (s_q.st)
      S_IDLE: begin
        s_d.ready = 1'b1;
        if (i_cmd_valid) begin
          // sequences always issued whole
          // A command is never interleaved with another, so no sequence is broken.
          s_d.ready = 1'b0;
          s_d.st = S_ISSUE;
          s_d.op = i_cmd_op;
          s_d.addr = i_cmd_addr;
          s_d.data = i_cmd_data;
          s_d.step = 3'd0;
          s_d.fail = 1'b0;
          s_d.fail_seen = 1'b0;
        end
      end
      S_ISSUE: begin
        s_d.st = S_WAIT;
        s_d.start = 1'b1;
        s_d.wr = w[ADDR_W+8];
        s_d.cyc_addr = w[ADDR_W+7:8];
        s_d.cyc_data = w[7:0];
      end
      S_WAIT: begin
        if (eng_done) begin
          if (!s_q.wr) begin
            s_d.rdata = eng_rdata;
          end
          if (s_q.step != last_step(s_q.op)) begin
            s_d.step = s_q.step + 3'd1;
            s_d.st = S_ISSUE;
          end else if (s_q.op == NFS_OP_PROGRAM || s_q.op == NFS_OP_CHIP_ERASE ||
                       s_q.op == NFS_OP_SECTOR_ERASE) begin
            s_d.st = S_POLL1;
          end else if (s_q.op == NFS_OP_SUSPEND) begin
            s_d.cnt = HALT_CNT_W'(SUSPEND_HALT_CYC - 1);
            s_d.st = S_HALT;
          end else begin
            s_d.st = S_FINISH;
          end
        end
      end
      S_POLL1: begin
        s_d.st = S_POLLW1;
        s_d.start = 1'b1;
        s_d.wr = 1'b0;
        s_d.cyc_addr = s_q.addr;
      end
      S_POLLW1: begin
        if (eng_done) begin
          s_d.prev = eng_rdata;
          s_d.st = S_POLL2;
        end
      end
      S_POLL2: begin
        s_d.st = S_POLLW2;
        s_d.start = 1'b1;
        s_d.wr = 1'b0;
        s_d.cyc_addr = s_q.addr;
      end
      S_POLLW2: begin
        if (eng_done) begin
          s_d.rdata = eng_rdata;
          if (eng_rdata[ALTERNATING_STATUS_BIT] == s_q.prev[ALTERNATING_STATUS_BIT]) begin
            s_d.st = S_FINISH;
          end else if (s_q.fail_seen) begin
            s_d.st = S_RECOVER;
          end else begin
            // The toggle may have stopped as the flag rose, so poll once more.
            s_d.fail_seen = eng_rdata[TIME_LIMIT_FAIL_FLAG];
            s_d.st = S_POLL1;
          end
        end
      end
      S_RECOVER: begin
        s_d.st = S_RECOVERW;
        s_d.start = 1'b1;
        s_d.wr = 1'b1;
        s_d.cyc_addr = s_q.addr;
        s_d.cyc_data = CMD_RESET;
      end
      S_RECOVERW: begin
        if (eng_done) begin
          s_d.fail = 1'b1;
          s_d.done = 1'b1;
          s_d.ready = 1'b1;
          s_d.st = S_IDLE;
        end
      end
      S_HALT: begin
        if (s_q.cnt == '0) begin
          s_d.st = S_FINISH;
        end else begin
          s_d.cnt = s_q.cnt - HALT_CNT_W'(1);
        end
      end
      S_FINISH: begin
        s_d.done = 1'b1;
        s_d.ready = 1'b1;
        s_d.st = S_IDLE;
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '{st: S_IDLE, op: NFS_OP_READ, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Pin engine
  nfs_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_start(s_q.start),
    .i_wr(s_q.wr),
    .i_addr(s_q.cyc_addr),
    .i_data(s_q.cyc_data),
    .i_dq_in(i_dq_in),
    .o_idle(),
    .o_done(eng_done),
    .o_rdata(eng_rdata),
    .o_ce_n(o_ce_n),
    .o_we_n(o_we_n),
    .o_oe_n(o_oe_n),
    .o_addr(o_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe_n(o_dq_oe_n)
  );

  assign o_cmd_ready = s_q.ready;
  assign o_done = s_q.done;
  assign o_fail = s_q.fail;
  assign o_rdata = s_q.rdata;

endmodule
`default_nettype wire

// *** nfs_pkg.sv ***
// Shared constants and types for the NOR flash command sequencer (host end).
// Assumes a 20 MHz core clock; all pin timing is derived from it here.
package nfs_pkg;

  // ==========================================================================
  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_MHZ = 20;
  localparam int SETUP_NS = 50;
  localparam int STROBE_NS = 100;
  localparam int HOLD_NS = 50;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Erase suspend settle time, waited in full before the suspend is reported.
  localparam int SUSPEND_HALT_US = 20;
  localparam int SUSPEND_HALT_CYC = SUSPEND_HALT_US * CLK_MHZ;
  localparam int HALT_CNT_W = 9;

  // ==========================================================================
  // Command cycle addresses and data codes
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;

  // ==========================================================================
  // Status bit positions on the data pins
  localparam int POLLING_STATUS_BIT = 7;
  localparam int ALTERNATING_STATUS_BIT = 6;
  localparam int TIME_LIMIT_FAIL_FLAG = 5;

  // ==========================================================================
  // User operations
  typedef enum logic [2:0] {
    NFS_OP_READ,
    NFS_OP_RESET,
    NFS_OP_IDENT,
    NFS_OP_PROGRAM,
    NFS_OP_CHIP_ERASE,
    NFS_OP_SECTOR_ERASE,
    NFS_OP_SUSPEND,
    NFS_OP_RESUME
  } nfs_op_t;

endpackage

// *** nfs_bus_cycle.sv ***
// Single bus cycle engine: one read or one write on the flash pins.
// Assumes the caller pulses i_start only while o_idle is high.
`timescale 1ns/100ps
`default_nettype none
module nfs_bus_cycle #(
  parameter int ADDR_W = 20
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic i_wr,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic [7:0] i_dq_in,
  output logic o_idle,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic [7:0] o_dq_out,
  output logic o_dq_oe_n
);
  import nfs_pkg::*;

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} nfs_eng_st_t;

  typedef struct packed {
    nfs_eng_st_t st;
    logic [3:0] cnt;
    logic wr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq;
    logic [7:0] rdata;
    logic done;
  } nfs_eng_t;

  nfs_eng_t s_q, s_d;

  // ==========================================================================
  // Cycle sequencing
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      E_IDLE: begin
        if (i_start) begin
          s_d.st = E_SETUP;
          s_d.wr = i_wr;
          s_d.addr = i_addr;
          s_d.dq = i_data;
          s_d.ce_n = 1'b0;
          s_d.dq_oe_n = ~i_wr;
          s_d.cnt = 4'(SETUP_CYC - 1);
        end
      end
      E_SETUP: begin
        if (s_q.cnt == 4'h0) begin
          // address before strobe
          // The address is settled before the later falling edge, so it is latched cleanly.
          s_d.st = E_PULSE;
          s_d.we_n = ~s_q.wr;
          s_d.oe_n = s_q.wr;
          s_d.cnt = 4'(STROBE_CYC - 1);
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      E_PULSE: begin
        if (s_q.cnt == 4'h0) begin
          // data past rise
          // Data keeps driving through the hold phase, past the first rising edge.
          s_d.st = E_HOLD;
          s_d.we_n = 1'b1;
          s_d.oe_n = 1'b1;
          if (!s_q.wr) begin
            s_d.rdata = i_dq_in;
          end
          s_d.cnt = 4'(HOLD_CYC - 1);
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      E_HOLD: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st = E_IDLE;
          s_d.ce_n = 1'b1;
          s_d.dq_oe_n = 1'b1;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: begin
        s_d.st = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '{st: E_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_idle = (s_q.st == E_IDLE);
  assign o_done = s_q.done;
  assign o_rdata = s_q.rdata;
  assign o_ce_n = s_q.ce_n;
  assign o_we_n = s_q.we_n;
  assign o_oe_n = s_q.oe_n;
  assign o_addr = s_q.addr;
  assign o_dq_out = s_q.dq;
  assign o_dq_oe_n = s_q.dq_oe_n;

endmodule
`default_nettype wire

// *** nfs_host_ctrl_asserts.sv ***
// Checker for the sequencer's command port and flash pin timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module nfs_host_ctrl_asserts #(
  parameter int ADDR_W = 20
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_cmd_valid,
  input wire nfs_pkg::nfs_op_t i_cmd_op,
  input wire logic o_cmd_ready,
  input wire logic o_done,
  input wire logic o_fail,
  input wire logic [7:0] o_dq_out,
  input wire logic o_dq_oe_n,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic o_ce_n,
  input wire logic o_we_n,
  input wire logic o_oe_n
);
  import nfs_pkg::*;
  // ====================================================================
  // Pin and port relations
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_take(nfs_op_t op);
    i_cmd_valid && o_cmd_ready && i_cmd_op == op;
  endsequence
  sequence s_write_of(logic [7:0] d);
    $fell(o_we_n) && o_dq_out == d;
  endsequence
  sequence s_wr_tail;
    !o_we_n && $stable(o_addr) ##1 o_we_n && !o_ce_n ##1 $stable(o_addr) && $stable(o_dq_out);
  endsequence
  property p_done_pulse;
    o_done |-> o_cmd_ready ##1 !o_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single idle pulse");
  property p_idle_pins;
    o_cmd_ready |-> o_ce_n && o_we_n && o_oe_n && o_dq_oe_n;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("pins active while idle");
  property p_wr_select;
    !o_we_n |-> !o_ce_n && !o_dq_oe_n && o_oe_n;
  endproperty
  a_wr_select: assert property (p_wr_select) else $error("write strobe without select");
  property p_wr_strobe;
    $fell(o_we_n) |-> $stable(o_addr) && $stable(o_dq_out) ##1 s_wr_tail;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe shape wrong");
  property p_rd_pulse;
    $fell(o_oe_n) |-> !o_ce_n && o_dq_oe_n ##1 !o_oe_n ##1 o_oe_n;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe shape wrong");
  property p_reset_cmd;
    s_take(NFS_OP_RESET) |-> ##[1:6] s_write_of(CMD_RESET) ##[1:8] o_done;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset write missing");
  property p_unlock_first;
    i_cmd_valid && o_cmd_ready && i_cmd_op inside {NFS_OP_IDENT, NFS_OP_PROGRAM,
      NFS_OP_CHIP_ERASE, NFS_OP_SECTOR_ERASE} |->
      ##[1:6] s_write_of(UNLOCK1_DATA) ##0 o_addr[11:0] == UNLOCK1_ADDR;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("first unlock wrong");
  property p_suspend_cmd;
    s_take(NFS_OP_SUSPEND) |-> ##[1:6] s_write_of(CMD_SUSPEND);
  endproperty
  a_suspend_cmd: assert property (p_suspend_cmd) else $error("suspend write missing");
  property p_fail_done;
    $rose(o_fail) |-> o_done;
  endproperty
  a_fail_done: assert property (p_fail_done) else $error("fail rose outside done");
endmodule
bind nfs_host_ctrl nfs_host_ctrl_asserts #(.ADDR_W(ADDR_W)) nfs_host_ctrl_asserts_inst (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid),
  .i_cmd_op(i_cmd_op), .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_fail(o_fail),
  .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n), .o_addr(o_addr), .o_ce_n(o_ce_n),
  .o_we_n(o_we_n), .o_oe_n(o_oe_n)
);
`default_nettype wire

// *** nfs_flash_model.sv ***
// Behavioural parallel flash on the far side of the host sequencer.
// Assumes writes end on a rising write strobe and reads start on falling enable.
`timescale 1ns/100ps
`default_nettype none
module nfs_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] PART_CODE = 8'hC3
) (
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [19:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_stuck,
  input wire logic i_slow,
  output logic [7:0] o_dq,
  output logic [7:0] o_wr_data,
  output logic o_bad
);
  import nfs_pkg::*;
  // ====================================================================
  // State (identity codes above are arbitrary)
  typedef enum logic [2:0] {FM_READ, FM_AUTO, FM_PROG, FM_CHIP, FM_SECT, FM_SUSP} nfs_fm_t;
  logic [7:0] mem [logic [19:0]];
  logic [19:0] wa = 20'h0_0000;
  logic [7:0] pv = 8'h00, last = 8'h00, cmd = 8'h00;
  logic [3:0] sec = 4'h0;
  logic tog = 1'b0, fail = 1'b0;
  nfs_fm_t md = FM_READ, back = FM_READ;
  int step = 0, left = 0;
  initial o_bad = 1'b0;
  initial o_wr_data = 8'h00;
  // Released bus shows the inverse, so a late sample cannot pass by luck.
  assign o_dq = (!i_ce_n && !i_oe_n) ? last : ~last;
  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  task automatic start(input nfs_fm_t m);
    md = m;
    fail = i_stuck;
    left = i_slow ? 12 : 2;
  endtask
  task automatic end_op();
    if (md == FM_CHIP) mem.delete();
    if (md == FM_SECT) foreach (mem[k]) if (k[19:16] == sec) mem[k] = 8'hFF;
    md = back;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    logic un1, ok;
    un1 = a[11:0] == UNLOCK1_ADDR;
    o_wr_data = d;
    if (md inside {FM_PROG, FM_CHIP, FM_SECT}) begin
      if (fail && d == CMD_RESET) begin
        fail = 1'b0;
        md = back;
      end
      if (md == FM_SECT && d == CMD_SUSPEND) md = FM_SUSP;
      return;
    end
    if (md == FM_SUSP && step == 0 && d == CMD_RESUME) begin
      md = FM_SECT;
      back = FM_READ;
      return;
    end
    if (d == CMD_RESET) begin
      step = 0;
      if (md == FM_AUTO) md = FM_READ;
      return;
    end
    back = (md == FM_SUSP) ? FM_SUSP : FM_READ;
    if (step == 3 && cmd == CMD_PROGRAM) begin
      step = 0;
      mem[a] = rd(a) & d;
      pv = d;
      start(FM_PROG);
      return;
    end
    case (step)
      0, 3: ok = un1 && d == UNLOCK1_DATA;
      1, 4: ok = a[11:0] == UNLOCK2_ADDR && d == UNLOCK2_DATA;
      2: ok = un1 && d inside {CMD_AUTOSEL, CMD_PROGRAM, CMD_ERASE_SETUP};
      default: ok = d == CMD_SECTOR_ERASE || (un1 && d == CMD_CHIP_ERASE);
    endcase
    if (!ok) begin
      o_bad = o_bad | (step != 0);
      step = 0;
      md = back;
      return;
    end
    if (step == 2) cmd = d;
    step++;
    if (step == 3 && cmd == CMD_AUTOSEL) begin
      step = 0;
      md = FM_AUTO;
    end
    if (step == 6) begin
      step = 0;
      sec = a[19:16];
      start(d == CMD_CHIP_ERASE ? FM_CHIP : FM_SECT);
    end
  endtask
  task automatic rdc(input logic [19:0] a);
    case (md)
      FM_AUTO: last = a[8:0] == 9'h100 ? MAKER_CODE : a[8:0] == 9'h101 ? PART_CODE :
        a[7:0] == 8'h02 ? {7'h00, a[19:16] == 4'h1} : 8'hFF;
      FM_SUSP: last = a[19:16] == sec ? {1'b1, tog, fail, 5'h00} : rd(a);
      FM_READ: last = rd(a);
      default: begin
        tog = ~tog;
        last = {md == FM_PROG ? ~pv[7] : 1'b0, tog, fail, 5'h00};
        left--;
        if (!fail && left <= 0) end_op();
      end
    endcase
  endtask
  // ====================================================================
  // Pin events
  // address at falling strobe
  always @(negedge i_we_n) if (!i_ce_n) wa = i_addr;
  always @(posedge i_we_n) if (!i_ce_n) wr(wa, i_dq);
  always @(negedge i_oe_n) if (!i_ce_n) rdc(i_addr);
endmodule
`default_nettype wire

// *** nfs_host_ctrl_tb_top.sv ***
// Self-checking bench: host sequencer driving the behavioural flash model.
// Assumes the checker binds itself to the sequencer.
`timescale 1ns/100ps
`default_nettype none
module nfs_host_ctrl_tb_top;
  import nfs_pkg::*;
  // ====================================================================
  // Harness (identity codes are arbitrary)
  localparam logic [7:0] MAKER = 8'h5A;
  localparam logic [7:0] PART = 8'hC3;
  logic clk = 1'b0, rstn = 1'b0, valid = 1'b0, stuck = 1'b0, slow = 1'b0;
  nfs_op_t op = NFS_OP_READ;
  logic [19:0] addr = 20'h0_0000;
  logic [19:0] fa;
  logic [7:0] data = 8'h00;
  logic [7:0] dq_out, fdq, line, rdata, wr_data;
  logic ready, done, fail, dq_oe_n, ce_n, we_n, oe_n, bad;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  assign line = !dq_oe_n ? dq_out : fdq;
  nfs_host_ctrl #(.ADDR_W(20)) nfs_host_ctrl_inst (
    .i_core_clk(clk), .i_rstn(rstn), .i_cmd_valid(valid), .i_cmd_op(op),
    .i_cmd_addr(addr), .i_cmd_data(data), .o_cmd_ready(ready), .o_done(done),
    .o_fail(fail), .o_rdata(rdata), .i_dq_in(line), .o_dq_out(dq_out),
    .o_dq_oe_n(dq_oe_n), .o_addr(fa), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n)
  );
  nfs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) nfs_flash_model_inst (
    .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(fa), .i_dq(line),
    .i_stuck(stuck), .i_slow(slow), .o_dq(fdq), .o_wr_data(wr_data), .o_bad(bad)
  );
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input nfs_op_t o, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    op <= o;
    addr <= a;
    data <= d;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check("done pulse", 8'h01, {7'h00, done});
  endtask
  // ====================================================================
  // Scenarios
  task automatic t_ident();
    logic [19:0] a [4] = '{20'h0_0100, 20'h0_0101, 20'h1_0002, 20'h2_0002};
    logic [7:0] e [4] = '{MAKER, PART, 8'h01, 8'h00};
    for (int i = 0; i < 4; i++) begin
      run(NFS_OP_IDENT, a[i], 8'h00);
      check("ident code", e[i], rdata);
    end
    run(NFS_OP_READ, 20'h0_0100, 8'h00);
    check("read after ident", 8'hFF, rdata);
  endtask
  task automatic t_program();
    slow <= 1'b1;
    run(NFS_OP_PROGRAM, 20'h3_0010, 8'hA5);
    slow <= 1'b0;
    run(NFS_OP_PROGRAM, 20'h5_0001, 8'h3C);
    check("program fail", 8'h00, {7'h00, fail});
    run(NFS_OP_READ, 20'h3_0010, 8'h00);
    check("programmed byte", 8'hA5, rdata);
    run(NFS_OP_READ, 20'h5_0001, 8'h00);
    check("second byte", 8'h3C, rdata);
  endtask
  task automatic t_fail();
    stuck <= 1'b1;
    run(NFS_OP_PROGRAM, 20'h6_0000, 8'h0F);
    stuck <= 1'b0;
    check("fail flag", 8'h01, {7'h00, fail});
    check("reset after fail", CMD_RESET, wr_data);
    run(NFS_OP_READ, 20'h3_0010, 8'h00);
    check("fail cleared", 8'h00, {7'h00, fail});
    check("read after fail", 8'hA5, rdata);
  endtask
  task automatic t_single();
    nfs_op_t ops [3] = '{NFS_OP_SUSPEND, NFS_OP_RESUME, NFS_OP_RESET};
    logic [7:0] codes [3] = '{CMD_SUSPEND, CMD_RESUME, CMD_RESET};
    for (int i = 0; i < 3; i++) begin
      run(ops[i], 20'h7_1234, 8'h00);
      check("single write", codes[i], wr_data);
    end
    run(NFS_OP_READ, 20'h3_0010, 8'h00);
    check("read after singles", 8'hA5, rdata);
  endtask
  task automatic t_erase();
    run(NFS_OP_SECTOR_ERASE, 20'h3_0000, 8'h00);
    run(NFS_OP_READ, 20'h3_0010, 8'h00);
    check("erased sector", 8'hFF, rdata);
    run(NFS_OP_READ, 20'h5_0001, 8'h00);
    check("other sector", 8'h3C, rdata);
    slow <= 1'b1;
    run(NFS_OP_CHIP_ERASE, 20'h0_0000, 8'h00);
    run(NFS_OP_READ, 20'h5_0001, 8'h00);
    check("chip erased", 8'hFF, rdata);
    check("sequence abort", 8'h00, {7'h00, bad});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_ident();
    t_program();
    t_fail();
    t_single();
    t_erase();
    wrap_up();
  end
  // A hang is cut short well past the 1200 or so cycles the run needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
